//--- rtl/path_monitor_params.svh
// register map, field layout, reset values and thresholds of the path monitor
`ifndef PATH_MONITOR_PARAMS_SVH
`define PATH_MONITOR_PARAMS_SVH

`define ADDR_W            8
`define DATA_W            32
`define ADDR_CTRL         8'h00
`define ADDR_THRESH       8'h04
`define ADDR_ES_CNT       8'h08
`define ADDR_SES_CNT      8'h0c
`define ADDR_BBE_CNT      8'h10
`define ADDR_FE_SES_CNT   8'h14
`define ADDR_LAST_SEC     8'h18
`define ADDR_IRQ_STATUS   8'h1c
`define ADDR_IRQ_ENABLE   8'h20
`define ADDR_IRQ_CLEAR    8'h24

`define CTRL_TYPE         1:0
`define CTRL_FMT          3:2
`define CTRL_CUSTOM       4
`define THRESH_FIELD      15:0
`define LAST_EB           13:0
`define LAST_CONSEC       29:16
`define IRQ_FIELD         2:0
`define IRQ_ES            0
`define IRQ_SES           1
`define IRQ_FE_SES        2

`define CTRL_TYPE_RST     2'h0
`define CTRL_FMT_RST      2'h1
`define THRESH_RST        16'h0000

// nominal thresholds per format
`define THR_1544          16'h0140
`define THR_2048          16'h0325
`define THR_44736         16'h098c
`define THR_44736_LEGACY  16'h002d

// bits per block per format
`define BITS_1544         13'h1218
`define BITS_2048         13'h0800
`define BITS_44736        13'h1298

`define CNT_W             32
`define SEC_W             14
`define BIT_W             13

`endif

//--- rtl/path_monitor_pkg.sv
// types shared by the path performance monitor
package path_monitor_pkg;
`include "path_monitor_params.svh"

    typedef enum logic [1:0] {
        PATH_FRAME_BLOCK = 2'h0,
        PATH_FRAME       = 2'h1,
        PATH_OTHER_FRAME = 2'h2,
        PATH_UNFRAMED    = 2'h3
    } path_type_e;

    typedef enum logic [1:0] {
        FMT_1544         = 2'h0,
        FMT_2048         = 2'h1,
        FMT_44736        = 2'h2,
        FMT_44736_LEGACY = 2'h3
    } fmt_e;

    typedef struct packed {
        path_type_e             ctrl_type;
        fmt_e                   ctrl_fmt;
        logic                   ctrl_custom;
        logic [15:0]            thresh;
        logic [`BIT_W-1:0]      bit_cnt;
        logic                   blk_anom;
        logic                   blk_def;
        logic                   blk_fae;
        logic                   prev_blk_fae;
        logic [`SEC_W-1:0]      sec_eb;
        logic                   sec_def;
        logic [`SEC_W-1:0]      consec;
        logic [`SEC_W-1:0]      rei_cnt;
        logic                   rdi_sec;
        logic [`CNT_W-1:0]      es_cnt;
        logic [`CNT_W-1:0]      ses_cnt;
        logic [`CNT_W-1:0]      bbe_cnt;
        logic [`CNT_W-1:0]      fe_ses_cnt;
        logic [`SEC_W-1:0]      last_eb;
        logic [`SEC_W-1:0]      last_consec;
        logic [2:0]             irq_status;
        logic [2:0]             irq_enable;
        logic [`DATA_W-1:0]     rdata;
    } monitor_state_s;

endpackage

//--- rtl/pdh_path_perf_monitor.sv
// per-path in-service error performance monitor for plesiochronous paths
//
// How it works
// - two anomaly strobes per block: frame word error and block check error.
// - three defect levels: signal lost, alarm indication, frame alignment lost.
// - anomalies only count while no enabled defect is present.
// - type 1 uses all three defects and both anomalies.
// - type 2 uses all defects and frame word errors only.
// - type 3 uses two defects, frame word errors, counts consecutive frame word errors.
// - type 4 uses only signal lost and alarm indication, no error checks.
// - a second with an enabled anomaly or defect is errored (types 1-3).
// - severely errored when anomaly blocks reach threshold or a defect occurs.
// - type 1 counts background block errors in seconds not severely errored.
// - at most one anomaly counted per block interval.
// - threshold settable to 320 or 805 for the two lower formats.
// - highest format threshold 2444, or 45 as legacy choice.
// - block length per format: 4632, 2048 or 4760 bits.
// - remote defect and error indications estimate far-end severe seconds.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "path_monitor_params.svh"
module pdh_path_perf_monitor
    import path_monitor_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    input  wire logic                 second_tick,
    input  wire logic                 bit_strobe,
    input  wire logic                 frame_align_error,
    input  wire logic                 block_check_error,
    input  wire logic                 signal_lost,
    input  wire logic                 alarm_indication_seen,
    input  wire logic                 frame_align_lost,
    input  wire logic                 remote_defect_indication,
    input  wire logic                 remote_error_indication,
    input  wire logic [`ADDR_W-1:0]   reg_addr,
    input  wire logic [`DATA_W-1:0]   reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [`DATA_W-1:0]   reg_rdata,
    output logic                      irq
);

    // saturating add, shared by the four 32-bit second and block counters
    function automatic logic [`CNT_W-1:0] sat_add(
        input logic [`CNT_W-1:0] a,
        input logic [`CNT_W-1:0] b
    );
        logic [`CNT_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[`CNT_W] ? '1 : s[`CNT_W-1:0];
    endfunction

    function automatic logic [`SEC_W-1:0] sat_inc14(
        input logic [`SEC_W-1:0] a,
        input logic              inc
    );
        logic [`SEC_W:0] s;
        s = {1'b0, a} + {{`SEC_W{1'b0}}, inc};
        return s[`SEC_W] ? '1 : s[`SEC_W-1:0];
    endfunction

    function automatic logic [15:0] default_thresh(input fmt_e f);
        case (f)
            FMT_1544:         return `THR_1544;
            FMT_2048:         return `THR_2048;
            FMT_44736:        return `THR_44736;
            default:          return `THR_44736_LEGACY;
        endcase
    endfunction

    function automatic logic [`BIT_W-1:0] block_bits(input fmt_e f);
        case (f)
            FMT_1544: return `BITS_1544;
            FMT_2048: return `BITS_2048;
            default:  return `BITS_44736;
        endcase
    endfunction

    // reset released through two flops
    logic rst_meta_b;
    logic rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    monitor_state_s st;
    monitor_state_s next_st;

    logic              use_fae;
    logic              use_bce;
    logic              use_lof;
    logic              unframed;
    logic              defect_now;
    logic              anom_now;
    logic              block_end;
    logic              block_counts;
    logic [15:0]       thr;
    logic [`SEC_W-1:0] eb_total;
    logic              sec_def_total;
    logic              is_ses;
    logic              is_es;
    logic              fe_ses;
    logic [`SEC_W-1:0] rei_total;
    logic [`SEC_W-1:0] consec_total;
    logic [2:0]        irq_set;
    logic [2:0]        irq_clr;

    always_comb begin
        use_fae  = (st.ctrl_type != PATH_UNFRAMED);
        use_bce  = (st.ctrl_type == PATH_FRAME_BLOCK);
        use_lof  = (st.ctrl_type == PATH_FRAME_BLOCK) ||
                   (st.ctrl_type == PATH_FRAME);
        unframed = (st.ctrl_type == PATH_UNFRAMED);
        defect_now = signal_lost || alarm_indication_seen ||
                     (use_lof && frame_align_lost);
        // anomalies seen during a defect are discarded
        anom_now = !defect_now &&
                   ((use_fae && frame_align_error) ||
                    (use_bce && block_check_error));
        block_end = bit_strobe &&
                    (st.bit_cnt == block_bits(st.ctrl_fmt) - `BIT_W'(1));
        // a block touched by a defect contributes no errored block
        block_counts = block_end && !unframed &&
                       (st.blk_anom || anom_now) &&
                       !(st.blk_def || defect_now);
        thr = st.ctrl_custom ? st.thresh : default_thresh(st.ctrl_fmt);
        eb_total = sat_inc14(st.sec_eb, block_counts);
        sec_def_total = st.sec_def || defect_now;
        is_ses = sec_def_total ||
                 (!unframed && ({2'b00, eb_total} >= thr));
        is_es = is_ses || (eb_total != '0);
        rei_total = sat_inc14(st.rei_cnt, remote_error_indication);
        fe_ses = st.rdi_sec || remote_defect_indication ||
                 ({2'b00, rei_total} >= thr);
        consec_total = sat_inc14(st.consec,
                                 block_end && st.prev_blk_fae &&
                                 (st.blk_fae || (frame_align_error && !defect_now)) &&
                                 st.ctrl_type == PATH_OTHER_FRAME);
        irq_set = '0;
        if (second_tick) begin
            irq_set[`IRQ_ES]     = is_es;
            irq_set[`IRQ_SES]    = is_ses;
            irq_set[`IRQ_FE_SES] = fe_ses;
        end
        irq_clr = (reg_wr && reg_addr == `ADDR_IRQ_CLEAR) ?
                  reg_wdata[`IRQ_FIELD] : 3'h0;
    end

    always_comb begin
        next_st = st;

        // block timing from the received bit strobe
        if (bit_strobe) begin
            next_st.bit_cnt = block_end ? '0 : st.bit_cnt + `BIT_W'(1);
        end
        if (block_end) begin
            next_st.blk_anom     = 1'b0;
            next_st.blk_def      = 1'b0;
            next_st.blk_fae      = 1'b0;
            next_st.prev_blk_fae = st.blk_fae || (frame_align_error && !defect_now);
        end else begin
            next_st.blk_anom = st.blk_anom || anom_now;
            next_st.blk_def  = st.blk_def || defect_now;
            next_st.blk_fae  = st.blk_fae || (use_fae && frame_align_error && !defect_now);
        end

        next_st.sec_eb  = eb_total;
        next_st.sec_def = sec_def_total;
        next_st.consec  = consec_total;
        next_st.rei_cnt = rei_total;
        next_st.rdi_sec = st.rdi_sec || remote_defect_indication;

        // second boundary closes the interval and restarts it
        if (second_tick) begin
            if (is_es && !unframed) begin
                next_st.es_cnt = sat_add(st.es_cnt, `CNT_W'(1));
            end else if (is_ses) begin
                // unframed paths: errored equals severely errored
                next_st.es_cnt = sat_add(st.es_cnt, `CNT_W'(1));
            end
            if (is_ses) begin
                next_st.ses_cnt = sat_add(st.ses_cnt, `CNT_W'(1));
            end
            if (use_bce && !is_ses) begin
                next_st.bbe_cnt = sat_add(st.bbe_cnt,
                                          {{(`CNT_W-`SEC_W){1'b0}}, eb_total});
            end
            if (fe_ses) begin
                next_st.fe_ses_cnt = sat_add(st.fe_ses_cnt, `CNT_W'(1));
            end
            next_st.last_eb     = eb_total;
            next_st.last_consec = consec_total;
            next_st.sec_eb      = '0;
            next_st.sec_def     = 1'b0;
            next_st.consec      = '0;
            next_st.rei_cnt     = '0;
            next_st.rdi_sec     = 1'b0;
        end

        // set wins over a clear in the same cycle
        next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;

        if (reg_wr) begin
            case (reg_addr)
                `ADDR_CTRL: begin
                    next_st.ctrl_type   = path_type_e'(reg_wdata[`CTRL_TYPE]);
                    next_st.ctrl_fmt    = fmt_e'(reg_wdata[`CTRL_FMT]);
                    next_st.ctrl_custom = reg_wdata[`CTRL_CUSTOM];
                    // block phase restarts with the new format
                    next_st.bit_cnt     = '0;
                end
                `ADDR_THRESH:     next_st.thresh     = reg_wdata[`THRESH_FIELD];
                `ADDR_ES_CNT:     next_st.es_cnt     = '0;
                `ADDR_SES_CNT:    next_st.ses_cnt    = '0;
                `ADDR_BBE_CNT:    next_st.bbe_cnt    = '0;
                `ADDR_FE_SES_CNT: next_st.fe_ses_cnt = '0;
                `ADDR_IRQ_ENABLE: next_st.irq_enable = reg_wdata[`IRQ_FIELD];
                default: begin
                end
            endcase
        end

        next_st.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_CTRL: begin
                    next_st.rdata[`CTRL_TYPE]   = st.ctrl_type;
                    next_st.rdata[`CTRL_FMT]    = st.ctrl_fmt;
                    next_st.rdata[`CTRL_CUSTOM] = st.ctrl_custom;
                end
                `ADDR_THRESH:     next_st.rdata[`THRESH_FIELD] = st.thresh;
                `ADDR_ES_CNT:     next_st.rdata = st.es_cnt;
                `ADDR_SES_CNT:    next_st.rdata = st.ses_cnt;
                `ADDR_BBE_CNT:    next_st.rdata = st.bbe_cnt;
                `ADDR_FE_SES_CNT: next_st.rdata = st.fe_ses_cnt;
                `ADDR_LAST_SEC: begin
                    next_st.rdata[`LAST_EB]     = st.last_eb;
                    next_st.rdata[`LAST_CONSEC] = st.last_consec;
                end
                `ADDR_IRQ_STATUS: next_st.rdata[`IRQ_FIELD] = st.irq_status;
                `ADDR_IRQ_ENABLE: next_st.rdata[`IRQ_FIELD] = st.irq_enable;
                default:          next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st             <= '0;
            st.ctrl_type   <= path_type_e'(`CTRL_TYPE_RST);
            st.ctrl_fmt    <= fmt_e'(`CTRL_FMT_RST);
            st.thresh      <= `THRESH_RST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign irq       = |(st.irq_status & st.irq_enable);

endmodule

//--- bench/monitor_checker_asserts.sv
// concurrent checks on the register port and interrupt of the path monitor
`timescale 1ns/1ps
`include "path_monitor_params.svh"
module monitor_checker (
    input wire logic               clk,
    input wire logic               rst_b,
    input wire logic               clk_en,
    input wire logic               second_tick,
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [`DATA_W-1:0] reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [`DATA_W-1:0] reg_rdata,
    input wire logic               irq
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    rdata_idle_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data left standing");
    unmapped_zero_a: assert property ($past(reg_rd && clk_en && reg_addr > 8'h24)
        |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_readback_a: assert property (reg_wr && clk_en && reg_addr == `ADDR_CTRL ##1 !reg_wr
        ##1 reg_rd && clk_en && reg_addr == `ADDR_CTRL |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 3))
        else $error("control readback differs");
    thresh_readback_a: assert property (reg_wr && clk_en && reg_addr == `ADDR_THRESH ##1 !reg_wr
        ##1 reg_rd && clk_en && reg_addr == `ADDR_THRESH
        |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 3))
        else $error("threshold readback differs");
    status_width_a: assert property ($past(reg_rd && clk_en && reg_addr == `ADDR_IRQ_STATUS)
        |-> reg_rdata[31:3] == 29'h0)
        else $error("status has stray bits");
    irq_mask_a: assert property (reg_wr && clk_en && reg_addr == `ADDR_IRQ_ENABLE
        && reg_wdata[2:0] == 3'h0 |=> ##1 !irq)
        else $error("masked interrupt still high");
    irq_cause_a: assert property ($changed(irq)
        |-> $past(second_tick || reg_wr) || $past(second_tick || reg_wr, 2))
        else $error("interrupt moved without cause");
    freeze_hold_a: assert property (!clk_en |=> $stable(reg_rdata) && $stable(irq))
        else $error("outputs moved while frozen");

    cover property ($rose(irq));
    cover property (reg_rd ##1 reg_rdata != 32'h0);
    cover property (!clk_en ##1 clk_en);
endmodule

bind pdh_path_perf_monitor monitor_checker chk_u (.clk, .rst_b, .clk_en, .second_tick,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);

//--- bench/framer_model.sv
// behavioural framer and block checker feeding the monitor's indications
`timescale 1ns/1ps
module framer_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [2:0] an_req,
    input  wire logic [3:0] df_req,
    output logic            bit_strobe,
    output logic            frame_align_error,
    output logic            block_check_error,
    output logic            remote_error_indication,
    output logic            signal_lost,
    output logic            alarm_indication_seen,
    output logic            frame_align_lost,
    output logic            remote_defect_indication
);
    // one bit per cycle keeps block edges predictable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_strobe <= 1'b0;
            {remote_error_indication, block_check_error, frame_align_error} <= 3'h0;
            {remote_defect_indication, frame_align_lost} <= 2'h0;
            {alarm_indication_seen, signal_lost} <= 2'h0;
        end else begin
            bit_strobe <= 1'b1;
            {remote_error_indication, block_check_error, frame_align_error} <= an_req;
            {remote_defect_indication, frame_align_lost} <= df_req[3:2];
            {alarm_indication_seen, signal_lost} <= df_req[1:0];
        end
    end
endmodule

//--- bench/pdh_path_perf_monitor_tb.sv
// self-checking bench for the path performance monitor
`timescale 1ns/1ps
`include "path_monitor_params.svh"
module pdh_path_perf_monitor_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic        second_tick = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [2:0]  anr = 3'h0;
    logic [3:0]  dfr = 4'h0;
    logic [4:0]  cur = 5'h04;
    logic [31:0] reg_rdata;
    logic        irq, bit_strobe, frame_align_error, block_check_error, signal_lost;
    logic        alarm_indication_seen, frame_align_lost;
    logic        remote_defect_indication, remote_error_indication;
    int          num_errors = 0;
    int          samples_checked = 0;

    always #2.5 clk = ~clk;
    framer_model part_u (.clk, .rst_b, .an_req(anr), .df_req(dfr), .bit_strobe,
        .frame_align_error, .block_check_error, .signal_lost, .alarm_indication_seen,
        .frame_align_lost, .remote_defect_indication, .remote_error_indication);
    pdh_path_perf_monitor dut_u (.clk, .rst_b, .clk_en, .second_tick, .bit_strobe,
        .frame_align_error, .block_check_error, .signal_lost, .alarm_indication_seen,
        .frame_align_lost, .remote_defect_indication, .remote_error_indication,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, reg_rdata, e);
        @(posedge clk);
    endtask
    task automatic cnts(input logic [31:0] es, severely_errored_second, bbe, fe);
        rchk("es", `ADDR_ES_CNT, es);
        rchk("ses", `ADDR_SES_CNT, severely_errored_second);
        rchk("bbe", `ADDR_BBE_CNT, bbe);
        rchk("fe_ses", `ADDR_FE_SES_CNT, fe);
    endtask
    task automatic cfg(input logic [4:0] c, input logic [15:0] t);
        wr(`ADDR_ES_CNT, 32'h0);
        wr(`ADDR_SES_CNT, 32'h0);
        wr(`ADDR_BBE_CNT, 32'h0);
        wr(`ADDR_FE_SES_CNT, 32'h0);
        wr(`ADDR_IRQ_ENABLE, 32'h0);
        wr(`ADDR_IRQ_CLEAR, 32'h7);
        wr(`ADDR_THRESH, {16'h0, t});
        rchk("thresh", `ADDR_THRESH, {16'h0, t});
        cur = c;
        wr(`ADDR_CTRL, {27'h0, c});
        rchk("ctrl", `ADDR_CTRL, {27'h0, c});
    endtask
    // restart blocks so each anomaly lands well inside a 2048-bit block
    task automatic sec(input int nb, input logic [2:0] an, input logic [3:0] df);
        wr(`ADDR_CTRL, {27'h0, cur});
        dfr <= df;
        repeat (nb) begin
            repeat (10) @(posedge clk);
            anr <= an;
            @(posedge clk);
            anr <= 3'h0;
            repeat (2037) @(posedge clk);
        end
        dfr <= 4'h0;
        repeat (20) @(posedge clk);
        second_tick <= 1'b1;
        @(posedge clk);
        second_tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        rchk("ctrl_rst", `ADDR_CTRL, 32'h4);
        rchk("thresh_rst", `ADDR_THRESH, 32'h0);
        cnts(0, 0, 0, 0);
        rchk("unmapped", 8'h40, 32'h0);
        wr(`ADDR_IRQ_STATUS, 32'h7);
        rchk("status_ro", `ADDR_IRQ_STATUS, 32'h0);
        // a write while frozen must be lost
        clk_en <= 1'b0;
        wr(`ADDR_THRESH, 32'h55);
        @(posedge clk);
        clk_en <= 1'b1;
        rchk("thresh_frozen", `ADDR_THRESH, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_bbe();
        cfg(5'h14, 16'h3);
        sec(2, 3'h3, 4'h0);
        cnts(1, 0, 2, 0);
        rchk("last_sec", `ADDR_LAST_SEC, 32'h2);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wr(`ADDR_IRQ_ENABLE, 32'h1);
        chk("irq_on", {31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ_CLEAR, 32'h1);
        chk("irq_off", {31'h0, irq}, 32'h0);
        $display("test bbe done");
    endtask
    task automatic t_ses();
        cfg(5'h14, 16'h2);
        sec(2, 3'h1, 4'h0);
        cnts(1, 1, 0, 0);
        rchk("status", `ADDR_IRQ_STATUS, 32'h3);
        $display("test ses done");
    endtask
    task automatic t_type2();
        cfg(5'h15, 16'h3);
        sec(2, 3'h2, 4'h0);
        cnts(0, 0, 0, 0);
        sec(1, 3'h1, 4'h0);
        cnts(1, 0, 0, 0);
        $display("test type2 done");
    endtask
    task automatic t_defect();
        cfg(5'h14, 16'h3);
        sec(1, 3'h1, 4'h4);
        cnts(1, 1, 0, 0);
        sec(1, 3'h0, 4'h2);
        cnts(2, 2, 0, 0);
        $display("test defect done");
    endtask
    task automatic t_type3();
        cfg(5'h16, 16'h5);
        sec(1, 3'h0, 4'h4);
        cnts(0, 0, 0, 0);
        sec(3, 3'h1, 4'h0);
        cnts(1, 0, 0, 0);
        rchk("consec", `ADDR_LAST_SEC, 32'h00020003);
        $display("test type3 done");
    endtask
    task automatic t_type4();
        cfg(5'h17, 16'h5);
        sec(1, 3'h3, 4'h4);
        cnts(0, 0, 0, 0);
        sec(1, 3'h0, 4'h1);
        cnts(1, 1, 0, 0);
        $display("test type4 done");
    endtask
    task automatic t_far();
        cfg(5'h14, 16'h2);
        sec(2, 3'h4, 4'h0);
        cnts(0, 0, 0, 1);
        sec(1, 3'h0, 4'h8);
        cnts(0, 0, 0, 2);
        rchk("fe_status", `ADDR_IRQ_STATUS, 32'h4);
        $display("test far done");
    endtask
    // three anomalies 2048 cycles apart all fall in one longer block
    task automatic t_fmt();
        cfg(5'h10, 16'h5);
        sec(3, 3'h1, 4'h0);
        cnts(1, 0, 1, 0);
        rchk("last_1544", `ADDR_LAST_SEC, 32'h1);
        cfg(5'h18, 16'h5);
        sec(3, 3'h1, 4'h0);
        cnts(1, 0, 1, 0);
        rchk("last_44736", `ADDR_LAST_SEC, 32'h1);
        $display("test fmt done");
    endtask
    task automatic t_rerst();
        wr(`ADDR_IRQ_ENABLE, 32'h1);
        chk("irq_pre_rst", {31'h0, irq}, 32'h1);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq_rerst", {31'h0, irq}, 32'h0);
        cnts(0, 0, 0, 0);
        rchk("ctrl_rerst", `ADDR_CTRL, 32'h4);
        rchk("last_rerst", `ADDR_LAST_SEC, 32'h0);
        rchk("enable_rerst", `ADDR_IRQ_ENABLE, 32'h0);
        $display("test rerst done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_bbe();
        t_ses();
        t_type2();
        t_defect();
        t_type3();
        t_type4();
        t_far();
        t_fmt();
        t_rerst();
        report_and_stop();
    end
    // about 50k cycles of traffic expected
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
endmodule
